// *** pkg/fan_ramp_pkg.sv ***
package fan_ramp_pkg;

    // register bus geometry
    localparam int AXI_AW = 12;
    localparam int AXI_DW = 32;

    // printed register indexes, byte address is four times the index
    localparam logic [7:0] CTRL_IDX   = 8'h63;
    localparam logic [7:0] CFG6_IDX   = 8'h10;
    localparam logic [7:0] CFG1_IDX   = 8'h40;
    localparam logic [7:0] STATUS_IDX = 8'h70;
    localparam logic [AXI_AW-1:0] CTRL_ADDR   = {2'b00, CTRL_IDX, 2'b00};
    localparam logic [AXI_AW-1:0] CFG6_ADDR   = {2'b00, CFG6_IDX, 2'b00};
    localparam logic [AXI_AW-1:0] CFG1_ADDR   = {2'b00, CFG1_IDX, 2'b00};
    localparam logic [AXI_AW-1:0] STATUS_ADDR = {2'b00, STATUS_IDX, 2'b00};

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CFG6_RST = 8'h00;
    localparam logic       LOCK_RST = 1'b0;

    // control register fields
    localparam int LOCAL_CODE_LSB  = 0;
    localparam int LOCAL_EN_BIT    = 3;
    localparam int REMOTE2_CODE_LSB = 4;
    localparam int REMOTE2_EN_BIT  = 7;
    // configuration six fields
    localparam int TIMEBASE_BIT    = 7;
    localparam int LOCAL_SLOW_BIT  = 1;
    localparam int REMOTE2_SLOW_BIT = 2;
    // configuration one field
    localparam int LOCK_BIT        = 0;

    // ramp timing: full 0..100% ramp at code 000, in tenths of a second
    localparam longint CLK_HZ        = 100_000_000;
    localparam longint DUTY_FULL     = 255;
    localparam longint RAMP_TB0_DS   = 375;
    localparam longint RAMP_TB1_DS   = 522;
    localparam longint SLOT_TB0_CYC  = (RAMP_TB0_DS * CLK_HZ) / (10 * DUTY_FULL);
    localparam longint SLOT_TB1_CYC  = (RAMP_TB1_DS * CLK_HZ) / (10 * DUTY_FULL);
    localparam int     SLOW_FACTOR   = 4;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // one register write leaving the bus slave
    typedef struct packed {
        logic              en;
        logic [AXI_AW-1:0] addr;
        logic [AXI_DW-1:0] data;
        logic [3:0]        strb;
    } wr_cmd_type;

    // per-channel ramp settings
    typedef struct packed {
        logic       enable;
        logic [2:0] code;
    } ramp_cfg_type;

    // duty increment per time slot for each ramp code
    function automatic logic [7:0] ramp_step(input logic [2:0] code);
        case (code)
            3'd0: ramp_step = 8'h01;
            3'd1: ramp_step = 8'h02;
            3'd2: ramp_step = 8'h03;
            3'd3: ramp_step = 8'h04;
            3'd4: ramp_step = 8'h08;
            3'd5: ramp_step = 8'h0C;
            3'd6: ramp_step = 8'h18;
            default: ramp_step = 8'h30;
        endcase
    endfunction : ramp_step

endpackage : fan_ramp_pkg

// *** rtl/fan_ramp_axil.sv ***
`timescale 1ns/100ps
`default_nettype none
module fan_ramp_axil
    import fan_ramp_pkg::*;
(
    input  wire logic              i_mclk,    // system clock
    input  wire logic              i_sys_rst, // async reset, high
    input  wire logic              i_clk_en,  // freezes state when low
    input  wire logic [AXI_AW-1:0] i_awaddr,  // write address
    input  wire logic              i_awvalid, // write address valid
    output      logic              o_awready, // write address ready
    input  wire logic [AXI_DW-1:0] i_wdata,   // write data
    input  wire logic [3:0]        i_wstrb,   // write byte enables
    input  wire logic              i_wvalid,  // write data valid
    output      logic              o_wready,  // write data ready
    output      logic [1:0]        o_bresp,   // write response
    output      logic              o_bvalid,  // write response valid
    input  wire logic              i_bready,  // write response ready
    input  wire logic [AXI_AW-1:0] i_araddr,  // read address
    input  wire logic              i_arvalid, // read address valid
    output      logic              o_arready, // read address ready
    output      logic [AXI_DW-1:0] o_rdata,   // read data
    output      logic [1:0]        o_rresp,   // read response
    output      logic              o_rvalid,  // read data valid
    input  wire logic              i_rready,  // read data ready
    output      wr_cmd_type        o_wr,      // register write strobe
    output      logic [AXI_AW-1:0] o_rd_addr, // address being read
    input  wire logic [AXI_DW-1:0] i_rd_data, // decoded read data
    input  wire logic              i_rd_hit,  // read address mapped
    input  wire logic              i_wr_hit   // write address mapped
);
    typedef struct packed {
        logic              aw_full;
        logic [AXI_AW-1:0] awaddr;
        logic              w_full;
        logic [AXI_DW-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [AXI_DW-1:0] rdata;
    } axil_state_type;

    axil_state_type s_q;
    axil_state_type s_d;
    logic           do_wr;
    logic           take_ar;

    // address and data taken in either order, one write at a time
    assign o_awready = !s_q.aw_full && !s_q.bvalid;
    assign o_wready  = !s_q.w_full && !s_q.bvalid;
    assign o_arready = !s_q.rvalid;
    assign do_wr     = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    assign take_ar   = i_arvalid && !s_q.rvalid;
    assign o_rd_addr = i_araddr;

    assign o_wr.en   = do_wr && i_clk_en;
    assign o_wr.addr = s_q.awaddr;
    assign o_wr.data = s_q.wdata;
    assign o_wr.strb = s_q.wstrb;

    assign o_bvalid = s_q.bvalid;
    assign o_bresp  = s_q.bresp;
    assign o_rvalid = s_q.rvalid;
    assign o_rresp  = s_q.rresp;
    assign o_rdata  = s_q.rdata;

    // channel handshakes
    always_comb begin
        s_d = s_q;
        if (i_awvalid && o_awready) begin
            s_d.aw_full = 1'b1;
            s_d.awaddr  = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            s_d.w_full = 1'b1;
            s_d.wdata  = i_wdata;
            s_d.wstrb  = i_wstrb;
        end
        if (do_wr) begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = i_wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_q.bvalid && i_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (take_ar) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = i_rd_hit ? i_rd_data : '0;
            s_d.rresp  = i_rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_q.rvalid && i_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '0;
        end else if (i_clk_en) begin
            s_q <= s_d;
        end
    end
endmodule : fan_ramp_axil
`default_nettype wire

// *** rtl/fan_ramp_channel.sv ***
`timescale 1ns/100ps
`default_nettype none
module fan_ramp_channel
    import fan_ramp_pkg::*;
(
    input  wire logic         i_mclk,    // system clock
    input  wire logic         i_sys_rst, // async reset, high
    input  wire logic         i_clk_en,  // freezes state when low
    input  wire ramp_cfg_type i_cfg,     // enable and ramp code
    input  wire logic         i_step,    // end of this channel's slot
    input  wire logic [7:0]   i_target,  // newly computed duty
    output      logic [7:0]   o_duty     // fan drive duty
);
    typedef struct packed {
        logic [7:0] duty;
    } chan_state_type;

    chan_state_type s_q;
    chan_state_type s_d;
    logic [7:0]     inc;
    logic [7:0]     gap;

    assign inc    = ramp_step(i_cfg.code);
    assign gap    = (s_q.duty < i_target) ? i_target - s_q.duty
                                          : s_q.duty - i_target;
    assign o_duty = s_q.duty;

    // follow target at once, or ramp one step per slot
    always_comb begin
        s_d = s_q;
        if (!i_cfg.enable) begin
            s_d.duty = i_target;
        end else if (i_step) begin
            if (gap <= inc) begin
                s_d.duty = i_target;
            end else if (s_q.duty < i_target) begin
                s_d.duty = s_q.duty + inc;
            end else begin
                s_d.duty = s_q.duty - inc;
            end
        end
    end

    // state register
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '0;
        end else if (i_clk_en) begin
            s_q <= s_d;
        end
    end
endmodule : fan_ramp_channel
`default_nettype wire

// *** rtl/fan_pwm_ramp_smoothing.sv ***
// How it works
// - lock bit makes control register read-only
// - slow-down bit makes ramp four times slower
// - bits 2:0 set local ramp rate
// - enabled channel ramps gradually toward new duty
// - codes map to steps 1,2,3,4,8,12,24,48
// - time base 0 gives 37.5s..0.8s ramps
// - time base 1 gives 52.2s..1.1s ramps
// - bit 3 enables local smoothing
// - bits 6:4 set remote 2 ramp rate
// - bit 7 enables remote 2 smoothing
// - control register resets to zero
`timescale 1ns/100ps
`default_nettype none
module fan_pwm_ramp_smoothing
    import fan_ramp_pkg::*;
#(
    parameter int SLOT_TB0_CYCLES = int'(SLOT_TB0_CYC), // slot, time base 0
    parameter int SLOT_TB1_CYCLES = int'(SLOT_TB1_CYC)  // slot, time base 1
) (
    input  wire logic              i_mclk,          // system clock, 100 MHz
    input  wire logic              i_sys_rst,       // async reset, high
    input  wire logic              i_clk_en,        // freezes state when low
    input  wire logic [AXI_AW-1:0] i_awaddr,        // write address
    input  wire logic              i_awvalid,       // write address valid
    output      logic              o_awready,       // write address ready
    input  wire logic [AXI_DW-1:0] i_wdata,         // write data
    input  wire logic [3:0]        i_wstrb,         // write byte enables
    input  wire logic              i_wvalid,        // write data valid
    output      logic              o_wready,        // write data ready
    output      logic [1:0]        o_bresp,         // write response
    output      logic              o_bvalid,        // write response valid
    input  wire logic              i_bready,        // write response ready
    input  wire logic [AXI_AW-1:0] i_araddr,        // read address
    input  wire logic              i_arvalid,       // read address valid
    output      logic              o_arready,       // read address ready
    output      logic [AXI_DW-1:0] o_rdata,         // read data
    output      logic [1:0]        o_rresp,         // read response
    output      logic              o_rvalid,        // read data valid
    input  wire logic              i_rready,        // read data ready
    input  wire logic [7:0]        i_local_target,  // local loop duty
    input  wire logic [7:0]        i_remote2_target, // remote 2 loop duty
    output      logic [7:0]        o_local_fan_drive_output,   // duty
    output      logic [7:0]        o_remote2_fan_drive_output  // duty
);
    localparam int NCH = 2;

    // refuse slot lengths the counter cannot serve
    if (SLOT_TB0_CYCLES < 1 || SLOT_TB1_CYCLES < 1) begin : g_bad_slot
        $error("slot lengths must be at least one cycle");
    end

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  cfg6;
        logic        lock;
        logic [31:0] slot_cnt;
        logic        tick;
        logic [1:0]  slow_div_l;
        logic [1:0]  slow_div_r;
    } top_state_type;

    top_state_type s_q;
    top_state_type s_d;
    wr_cmd_type    wr;
    logic [AXI_AW-1:0] rd_addr;
    logic [AXI_DW-1:0] rd_data;
    logic          rd_hit;
    logic          wr_hit;
    logic [31:0]   slot_len;
    ramp_cfg_type  cfg   [NCH];
    logic [NCH-1:0] slow;
    logic [NCH-1:0] step;
    logic [7:0]    target [NCH];
    logic [7:0]    duty   [NCH];

    // bus slave
    fan_ramp_axil u_axil (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_awaddr  (i_awaddr),
        .i_awvalid (i_awvalid),
        .o_awready (o_awready),
        .i_wdata   (i_wdata),
        .i_wstrb   (i_wstrb),
        .i_wvalid  (i_wvalid),
        .o_wready  (o_wready),
        .o_bresp   (o_bresp),
        .o_bvalid  (o_bvalid),
        .i_bready  (i_bready),
        .i_araddr  (i_araddr),
        .i_arvalid (i_arvalid),
        .o_arready (o_arready),
        .o_rdata   (o_rdata),
        .o_rresp   (o_rresp),
        .o_rvalid  (o_rvalid),
        .i_rready  (i_rready),
        .o_wr      (wr),
        .o_rd_addr (rd_addr),
        .i_rd_data (rd_data),
        .i_rd_hit  (rd_hit),
        .i_wr_hit  (wr_hit)
    );

    // address decode
    assign wr_hit = wr.addr == CTRL_ADDR || wr.addr == CFG6_ADDR ||
                    wr.addr == CFG1_ADDR || wr.addr == STATUS_ADDR;
    assign rd_hit = rd_addr == CTRL_ADDR || rd_addr == CFG6_ADDR ||
                    rd_addr == CFG1_ADDR || rd_addr == STATUS_ADDR;

    // read mux, narrow registers in the low bits
    always_comb begin
        rd_data = '0;
        case (rd_addr)
            CTRL_ADDR:   rd_data[7:0]  = s_q.ctrl;
            CFG6_ADDR:   rd_data[7:0]  = s_q.cfg6;
            CFG1_ADDR:   rd_data[LOCK_BIT] = s_q.lock;
            STATUS_ADDR: rd_data[15:0] = {duty[1], duty[0]};
            default:     rd_data = '0;
        endcase
    end

    assign cfg[0].code   = s_q.ctrl[LOCAL_CODE_LSB +: 3];
    assign cfg[0].enable = s_q.ctrl[LOCAL_EN_BIT];
    assign cfg[1].code   = s_q.ctrl[REMOTE2_CODE_LSB +: 3];
    assign cfg[1].enable = s_q.ctrl[REMOTE2_EN_BIT];
    assign slow[0]   = s_q.cfg6[LOCAL_SLOW_BIT];
    assign slow[1]   = s_q.cfg6[REMOTE2_SLOW_BIT];
    assign target[0] = i_local_target;
    assign target[1] = i_remote2_target;

    // time base 0 slot; time base 1 slot
    assign slot_len = s_q.cfg6[TIMEBASE_BIT] ? 32'(SLOT_TB1_CYCLES)
                                             : 32'(SLOT_TB0_CYCLES);

    assign step[0] = s_q.tick && (!slow[0] || s_q.slow_div_l == 2'd3);
    assign step[1] = s_q.tick && (!slow[1] || s_q.slow_div_r == 2'd3);

    // register writes, slot timer and slow dividers
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (wr.en && wr.strb[0]) begin
            if (wr.addr == CTRL_ADDR && !s_q.lock) begin
                s_d.ctrl = wr.data[7:0];
            end
            if (wr.addr == CFG6_ADDR) begin
                s_d.cfg6 = wr.data[7:0];
            end
            if (wr.addr == CFG1_ADDR && wr.data[LOCK_BIT]) begin
                s_d.lock = 1'b1;
            end
        end
        if (s_q.slot_cnt >= slot_len - 32'd1) begin
            s_d.slot_cnt = '0;
            s_d.tick     = 1'b1;
        end else begin
            s_d.slot_cnt = s_q.slot_cnt + 32'd1;
        end
        if (s_q.tick) begin
            s_d.slow_div_l = s_q.slow_div_l + 2'd1;
            s_d.slow_div_r = s_q.slow_div_r + 2'd1;
        end
    end

    // state register
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q.ctrl       <= CTRL_RST;
            s_q.cfg6       <= CFG6_RST;
            s_q.lock       <= LOCK_RST;
            s_q.slot_cnt   <= '0;
            s_q.tick       <= 1'b0;
            s_q.slow_div_l <= '0;
            s_q.slow_div_r <= '0;
        end else if (i_clk_en) begin
            s_q <= s_d;
        end
    end

    // one ramp per channel
    for (genvar c = 0; c < NCH; c++) begin : g_chan
        fan_ramp_channel u_chan (
            .i_mclk    (i_mclk),
            .i_sys_rst (i_sys_rst),
            .i_clk_en  (i_clk_en),
            .i_cfg     (cfg[c]),
            .i_step    (step[c]),
            .i_target  (target[c]),
            .o_duty    (duty[c])
        );
    end

    assign o_local_fan_drive_output   = duty[0];
    assign o_remote2_fan_drive_output = duty[1];

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    logic rst_seen_q;
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rst_seen_q <= 1'b1;
        end else begin
            rst_seen_q <= 1'b0;
        end
    end

    // register access
    a_lock_holds_ctrl: assert property (
        s_q.lock && wr.en && wr.addr == CTRL_ADDR |=> $stable(s_q.ctrl))
        else $error("control register changed while locked");

    a_lock_sticky: assert property (
        s_q.lock |=> s_q.lock)
        else $error("lock bit cleared without reset");

    a_ctrl_write_lands: assert property (
        i_clk_en && wr.en && wr.strb[0] && wr.addr == CTRL_ADDR && !s_q.lock
        |=> s_q.ctrl == $past(wr.data[7:0]))
        else $error("unlocked control write lost");

    // slow-down dividers
    a_slow_every_four: assert property (
        step[0] && slow[0] |-> s_q.slow_div_l == 2'd3)
        else $error("slowed local step off the fourth slot");

    a_slow_remote_four: assert property (
        step[1] && slow[1] |-> s_q.slow_div_r == 2'd3)
        else $error("slowed remote 2 step off the fourth slot");

    // step sizes per channel
    a_step_size_local: assert property (
        i_clk_en && cfg[0].enable && step[0] && $stable(i_local_target)
        && duty[0] != target[0] |=> duty[0] == target[0] ||
        duty[0] - $past(duty[0]) == ramp_step($past(cfg[0].code)) ||
        $past(duty[0]) - duty[0] == ramp_step($past(cfg[0].code)))
        else $error("local duty moved by the wrong step");

    a_step_size_remote: assert property (
        i_clk_en && cfg[1].enable && step[1] && $stable(i_remote2_target)
        && duty[1] != target[1] |=> duty[1] == $past(target[1]) ||
        duty[1] - $past(duty[1]) == ramp_step($past(cfg[1].code)) ||
        $past(duty[1]) - duty[1] == ramp_step($past(cfg[1].code)))
        else $error("remote 2 duty moved by the wrong step");

    // remote 2 duty holds between slots
    a_hold_between_slots: assert property (
        i_clk_en && cfg[1].enable && !step[1] |=> $stable(duty[1]))
        else $error("remote 2 duty moved between slots");

    // slot timer, a shortened slot may end late once
    a_tick_period: assert property (
        i_clk_en && s_q.tick |-> $past(s_q.slot_cnt) >= slot_len - 32'd1
        || $past(slot_len) != slot_len || !$past(i_clk_en))
        else $error("slot tick at wrong count");

    // disabled channels follow their target
    a_bypass_local: assert property (
        i_clk_en && !cfg[0].enable |=> duty[0] == $past(target[0]))
        else $error("disabled local channel not following target");

    a_bypass_remote: assert property (
        i_clk_en && !cfg[1].enable |=> duty[1] == $past(target[1]))
        else $error("disabled remote 2 channel not following target");

    // power-on state
    a_reset_zero: assert property (
        rst_seen_q |-> s_q.ctrl == 8'h00 && !s_q.lock)
        else $error("control register not zero after reset");

    // clamping at the target
    a_no_overshoot: assert property (
        i_clk_en && cfg[0].enable && duty[0] <= target[0] &&
        $stable(target[0]) ##1 $stable(target[0]) |-> duty[0] <= target[0])
        else $error("local ramp passed its target");

    a_remote_no_overshoot: assert property (
        i_clk_en && cfg[1].enable && duty[1] <= target[1] &&
        $stable(target[1]) ##1 $stable(target[1]) |-> duty[1] <= target[1])
        else $error("remote 2 ramp passed its target");

    // main scenarios
    c_locked_write: cover property (s_q.lock && wr.en);

    c_ramp_step: cover property (cfg[0].enable && step[0]
        && duty[0] != target[0]);

    c_slow_remote: cover property (slow[1] && step[1]);

    c_timebase_one: cover property (s_q.cfg6[TIMEBASE_BIT] && step[0]);

    c_locked_ramp: cover property (s_q.lock && cfg[1].enable && step[1]);
endmodule : fan_pwm_ramp_smoothing
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb
    import fan_ramp_pkg::*;
;
    localparam int SLOT0 = 20;
    localparam int SLOT1 = 28;

    logic              i_mclk;
    logic              i_sys_rst;
    logic [AXI_AW-1:0] i_awaddr;
    logic              i_awvalid;
    logic [AXI_DW-1:0] i_wdata;
    logic [3:0]        i_wstrb;
    logic              i_wvalid;
    logic              i_bready;
    logic [AXI_AW-1:0] i_araddr;
    logic              i_arvalid;
    logic              i_rready;
    logic [7:0]        i_local_target;
    logic [7:0]        i_remote2_target;
    logic              o_awready;
    logic              o_wready;
    logic              o_bvalid;
    logic              o_arready;
    logic              o_rvalid;
    logic [1:0]        o_bresp;
    logic [1:0]        o_rresp;
    logic [AXI_DW-1:0] o_rdata;
    logic [7:0]        o_local_fan_drive_output;
    logic [7:0]        o_remote2_fan_drive_output;
    // expected notes and bench state
    logic [33:0]       wq [$];
    logic [33:0]       rq [$];
    logic [23:0]       dq [2][$];
    logic [23:0]       note;
    logic [7:0]        seen;
    logic [7:0]        prev [2] = '{8'h00, 8'h00};
    logic [7:0]        ctl = 8'h00;
    logic [7:0]        cfg = 8'h00;
    int                gap [2] = '{0, 0};
    int                cur [2] = '{0, 0};
    int                step_tab [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
    int                miscompares = 0;
    int                checks_done = 0;

    // clock source, 10 ns period
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    fan_pwm_ramp_smoothing #(
        .SLOT_TB0_CYCLES(SLOT0),
        .SLOT_TB1_CYCLES(SLOT1)
    ) u_dut (
        .i_mclk                    (i_mclk),
        .i_sys_rst                 (i_sys_rst),
        .i_clk_en                  (1'b1),
        .i_awaddr                  (i_awaddr),
        .i_awvalid                 (i_awvalid),
        .o_awready                 (o_awready),
        .i_wdata                   (i_wdata),
        .i_wstrb                   (i_wstrb),
        .i_wvalid                  (i_wvalid),
        .o_wready                  (o_wready),
        .o_bresp                   (o_bresp),
        .o_bvalid                  (o_bvalid),
        .i_bready                  (i_bready),
        .i_araddr                  (i_araddr),
        .i_arvalid                 (i_arvalid),
        .o_arready                 (o_arready),
        .o_rdata                   (o_rdata),
        .o_rresp                   (o_rresp),
        .o_rvalid                  (o_rvalid),
        .i_rready                  (i_rready),
        .i_local_target            (i_local_target),
        .i_remote2_target          (i_remote2_target),
        .o_local_fan_drive_output  (o_local_fan_drive_output),
        .o_remote2_fan_drive_output(o_remote2_fan_drive_output)
    );

    task automatic check(input string what, input logic [33:0] got,
                         input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // one bus write, address and data offered together
    task automatic wr(input logic [AXI_AW-1:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        wq.push_back({r, 32'h0000_0000});
        @(posedge i_mclk);
        i_awaddr  <= a;
        i_awvalid <= 1'b1;
        i_wdata   <= {24'h00_0000, d};
        i_wstrb   <= s;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge i_mclk);
            if (!aw_ok && o_awready) begin
                aw_ok = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (!w_ok && o_wready) begin
                w_ok = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
        do @(posedge i_mclk); while (!o_bvalid);
        i_bready <= 1'b0;
    endtask : wr

    // one bus read, data expected in the low byte
    task automatic rd(input logic [AXI_AW-1:0] a, input logic [7:0] d,
                      input logic [1:0] r);
        rq.push_back({r, 24'h00_0000, d});
        @(posedge i_mclk);
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        do @(posedge i_mclk); while (!o_arready);
        i_arvalid <= 1'b0;
        do @(posedge i_mclk); while (!o_rvalid);
        i_rready <= 1'b0;
    endtask : rd

    // new random targets on both channels, notes every duty step
    task automatic ramp();
        int          t [2];
        int          s;
        int          g;
        int          v;
        int          r;
        logic [15:0] gg;
        for (int c = 0; c < 2; c++) begin
            r = $urandom_range(30, 90);
            t[c] = cur[c] >= 128 ? cur[c] - r : cur[c] + r;
            s = ctl[4*c+3] ? step_tab[ctl[4*c +: 3]] : 256;
            g = (cfg[7] ? SLOT1 : SLOT0) * (cfg[1+c] ? 4 : 1);
            v = cur[c];
            gg = 16'h0000;
            while (v != t[c]) begin
                v = v < t[c] ? ((v + s > t[c]) ? t[c] : v + s)
                             : ((v - s < t[c]) ? t[c] : v - s);
                dq[c].push_back({gg, 8'(v)});
                gg = ctl[4*c+3] ? 16'(g) : 16'h0000;
            end
            cur[c] = t[c];
        end
        i_local_target   <= 8'(t[0]);
        i_remote2_target <= 8'(t[1]);
        while (dq[0].size() != 0 || dq[1].size() != 0)
            @(posedge i_mclk);
    endtask : ramp

    // watch responses and duty changes, compare with oldest note
    always @(posedge i_mclk) begin
        if (o_bvalid && i_bready)
            check("bresp", {o_bresp, 32'h0000_0000}, wq.pop_front());
        if (o_rvalid && i_rready)
            check("read", {o_rresp, o_rdata}, rq.pop_front());
        for (int c = 0; c < 2; c++) begin
            seen = c ? o_remote2_fan_drive_output : o_local_fan_drive_output;
            gap[c]++;
            if (!i_sys_rst && seen !== prev[c]) begin
                note = dq[c].size() ? dq[c].pop_front() : 24'hxx_xxxx;
                check("duty", 34'(seen), 34'(note[7:0]));
                if (note[23:8] != 16'h0000)
                    check("slot gap", 34'(gap[c]), 34'(note[23:8]));
                gap[c] = 0;
            end
            prev[c] = seen;
        end
    end

    // main sequence
    initial begin
        i_sys_rst        = 1'b1;
        i_awaddr         = '0;
        i_awvalid        = 1'b0;
        i_wdata          = '0;
        i_wstrb          = 4'h0;
        i_wvalid         = 1'b0;
        i_bready         = 1'b0;
        i_araddr         = '0;
        i_arvalid        = 1'b0;
        i_rready         = 1'b0;
        i_local_target   = 8'h00;
        i_remote2_target = 8'h00;
        void'($urandom(41));
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(CTRL_ADDR, CTRL_RST, RESP_OKAY);
        ramp();
        // every ramp code on both channels, both time bases and both slow-down settings
        for (int k = 0; k < 8; k++) begin
            cfg = {k[2], 4'h0, k[1:0], 1'b0};
            ctl = {1'b1, 3'(7 - k), 1'b1, 3'(k)};
            wr(CFG6_ADDR, cfg, 4'hF, RESP_OKAY);
            wr(CTRL_ADDR, ctl, 4'hF, RESP_OKAY);
            rd(CTRL_ADDR, ctl, RESP_OKAY);
            ramp();
        end
        wr(12'h004, 8'hFF, 4'hF, RESP_SLVERR);
        rd(12'h004, 8'h00, RESP_SLVERR);
        wr(CTRL_ADDR, 8'h00, 4'h0, RESP_OKAY);
        rd(CTRL_ADDR, ctl, RESP_OKAY);
        wr(CFG1_ADDR, 8'h01, 4'hF, RESP_OKAY);
        wr(CTRL_ADDR, 8'h00, 4'hF, RESP_OKAY);
        rd(CTRL_ADDR, ctl, RESP_OKAY);
        ramp();
        conclude();
    end

    // hang guard, well beyond the longest ramp sequence
    initial begin
        repeat (60000) @(posedge i_mclk);
        miscompares++;
        conclude();
    end

endmodule : tb
`default_nettype wire
